//--- core/alert_status_shunt.sv
// status flags, alert mask/enable, shunt result format and two-wire register access
`timescale 1ns/1ps
`include "monitor_consts.svh"
module alert_status_shunt #(
    parameter logic [6:0] DEV_ADDR = `I2C_ADDR_DFLT
) (
    input  wire logic                 mclk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 conv_clk_i,
    input  wire monitor_pkg::conv_in_t conv_i,
    input  wire logic [7:0]           limit_flags_i,
    input  wire logic                 convert_i,
    input  wire logic                 scl_i,
    input  wire logic                 sda_i,
    output logic                      sda_o,
    output logic                      sda_oe_o,
    output monitor_pkg::pins_t        pins_o
);
    // ---------------- conversion domain ----------------
    logic [1:0]  crst_sync_r;
    logic        conv_rst_n;
    logic [15:0] cdata_r, cdata_nxt;
    logic        cdone_tgl_r, cdone_tgl_nxt;
    logic        covf_tgl_r, covf_tgl_nxt;

    always_ff @(posedge conv_clk_i)
    begin
        crst_sync_r <= {crst_sync_r[0], rst_n_i};
    end
    assign conv_rst_n = crst_sync_r[1];

    // data is frozen with the toggle so the far side samples a settled word
    always_comb
    begin
        cdata_nxt     = cdata_r;
        cdone_tgl_nxt = cdone_tgl_r;
        covf_tgl_nxt  = covf_tgl_r ^ conv_i.ovf;
        if (conv_i.done)
        begin
            cdata_nxt     = conv_i.shunt;
            cdone_tgl_nxt = !cdone_tgl_r;
        end
    end

    always_ff @(posedge conv_clk_i)
    begin
        if (!conv_rst_n)
        begin
            cdata_r     <= `ZERO_WORD;
            cdone_tgl_r <= 1'b0;
            covf_tgl_r  <= 1'b0;
        end
        else
        begin
            cdata_r     <= cdata_nxt;
            cdone_tgl_r <= cdone_tgl_nxt;
            covf_tgl_r  <= covf_tgl_nxt;
        end
    end

    // ---------------- synchronisers into mclk ----------------
    // order: scl, sda, convert, done toggle, ovf toggle, critical_pos_flag+, critical_pos_flag-
    logic [6:0] async_in, s1_r, s2_r, s3_r;
    assign async_in = {scl_i, sda_i, convert_i, cdone_tgl_r, covf_tgl_r,
                       conv_i.critical_pos_flag_pos, conv_i.critical_pos_flag_neg};

    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            // bus lines rest high, so reset must not fake a clock or data edge
            s1_r <= `SYNC_IDLE;
            s2_r <= `SYNC_IDLE;
            s3_r <= `SYNC_IDLE;
        end
        else
        begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    logic scl_s, sda_s, scl_rise, scl_fall, bus_start, bus_stop;
    logic conv_edge, cnv_evt, ovf_evt, critical_pos_flag_pos_s, critical_pos_flag_neg_s;
    assign scl_s      = s2_r[6];
    assign sda_s      = s2_r[5];
    assign scl_rise   = scl_s && !s3_r[6];
    assign scl_fall   = !scl_s && s3_r[6];
    assign bus_start  = scl_s && s3_r[6] && s3_r[5] && !sda_s;
    assign bus_stop   = scl_s && s3_r[6] && !s3_r[5] && sda_s;
    assign conv_edge  = s2_r[4] && !s3_r[4];
    assign cnv_evt    = s2_r[3] ^ s3_r[3];
    assign ovf_evt    = s2_r[2] ^ s3_r[2];
    assign critical_pos_flag_pos_s = s2_r[1];
    assign critical_pos_flag_neg_s = s2_r[0];

    // ---------------- register file ----------------
    logic [15:0] cfg_r, cfg_nxt, mask_r, mask_nxt, status_r, status_nxt;
    logic [15:0] shunt_r, shunt_nxt, st_set, st_clr, wr_data;
    logic        soft_r, soft_nxt, srst, wr_stb, rd_stb, cfg_wr, msk_wr;
    logic [7:0]  ptr_r, ptr_nxt;
    monitor_pkg::pins_t pins_r, pins_nxt;
    assign srst = !rst_n_i || soft_r;

    function automatic logic [15:0] read_word(input logic [7:0] ptr, input logic [15:0] cfg,
                                              input logic [15:0] st, input logic [15:0] msk,
                                              input logic [15:0] sh);
        case (ptr)
            `PTR_CONFIG: read_word = cfg;
            `PTR_STATUS: read_word = st;
            `PTR_MASK:   read_word = msk;
            `PTR_SHUNT:  read_word = sh;
            default:     read_word = `ZERO_WORD;
        endcase
    endfunction

    // range clamp
    // full scale doubles per gain step; clamping gives the repeated sign bits
    function automatic logic [15:0] shunt_clamp(input logic [15:0] raw, input logic [1:0] gain);
        logic [15:0] lim;
        logic [15:0] nlim;
        lim  = 16'(`SHUNT_FS_BASE << gain);
        nlim = 16'(`ZERO_WORD - lim);
        if ($signed(raw) > $signed(lim))
            shunt_clamp = lim;
        else if ($signed(raw) < $signed(nlim))
            shunt_clamp = nlim;
        else
            shunt_clamp = raw;
    endfunction

    always_comb
    begin
        cfg_nxt   = cfg_r;
        mask_nxt  = mask_r;
        shunt_nxt = shunt_r;
        soft_nxt  = 1'b0;
        cfg_wr    = wr_stb && (ptr_r == `PTR_CONFIG);
        msk_wr    = wr_stb && (ptr_r == `PTR_MASK);
        st_clr    = `ZERO_WORD;
        st_set    = `ZERO_WORD;
        if (cfg_wr)
        begin
            cfg_nxt  = {1'b0, wr_data[`CFG_SOFT_RST-1:0]};
            soft_nxt = wr_data[`CFG_SOFT_RST];
        end
        if (msk_wr)
            mask_nxt = wr_data & `MASK_WR_BITS;
        if (cnv_evt)
            shunt_nxt = shunt_clamp(cdata_r, cfg_r[`CFG_GAIN_HI:`CFG_GAIN_LO]);
        if (rd_stb)
            st_clr = `STATUS_USED;
        if (cfg_wr && wr_data[`CFG_MODE_HI:0] != `MODE_POWER_DOWN
                   && wr_data[`CFG_MODE_HI:0] != `MODE_ADC_OFF)
            st_clr[`ST_CONV_READY_FLAG] = 1'b1;
        if (conv_edge)
            st_clr[`ST_CONV_READY_FLAG] = 1'b1;
        if (!mask_r[`MSK_ALERT_EN])
            st_clr[`ST_ALERT] = 1'b1;
        st_set[`ST_TOP:`ST_LIMIT_LO] = limit_flags_i;
        st_set[`ST_CRITICAL_POS_FLAG_POS] = critical_pos_flag_pos_s;
        st_set[`ST_CRITICAL_POS_FLAG_NEG] = critical_pos_flag_neg_s;
        st_set[`ST_CONV_READY_FLAG] = cnv_evt;
        st_set[`ST_ALERT] = mask_r[`MSK_ALERT_EN]
                            && |(status_r[`ST_TOP:`ST_CONV_READY_FLAG] & mask_r[`ST_TOP:`ST_CONV_READY_FLAG]);
        st_set[`ST_OVF] = ovf_evt;
        status_nxt = ((status_r & ~st_clr) | st_set) & `STATUS_USED;
        pins_nxt.critical_pos_flag    = mask_r[`MSK_CRITICAL_POS_FLAG_EN] && (critical_pos_flag_pos_s || critical_pos_flag_neg_s);
        pins_nxt.limit   = mask_r[`MSK_LIMIT_EN] && |limit_flags_i[`LIM_LIMIT_HI:0];
        pins_nxt.warn    = mask_r[`MSK_WARN_EN]
                           && |limit_flags_i[`LIM_WARN_HI:`LIM_WARN_LO];
        pins_nxt.alert_n = !status_r[`ST_ALERT];
    end

    always_ff @(posedge mclk_i)
    begin
        if (srst)
        begin
            cfg_r    <= `CONFIG_RST_VAL;
            mask_r   <= `ZERO_WORD;
            status_r <= `ZERO_WORD;
            shunt_r  <= `ZERO_WORD;
            soft_r   <= 1'b0;
            pins_r   <= 4'h1;
        end
        else
        begin
            cfg_r    <= cfg_nxt;
            mask_r   <= mask_nxt;
            status_r <= status_nxt;
            shunt_r  <= shunt_nxt;
            soft_r   <= soft_nxt;
            pins_r   <= pins_nxt;
        end
    end
    assign pins_o = pins_r;

    // ---------------- two-wire slave ----------------
    monitor_pkg::bus_state_t state_r, state_nxt;
    monitor_pkg::rx_kind_t   kind_r, kind_nxt;
    logic [2:0]  cnt_r, cnt_nxt;
    logic [7:0]  shreg_r, shreg_nxt, wbuf_r, wbuf_nxt, rx_byte, tx_byte;
    logic [15:0] txw_r, txw_nxt;
    logic        ack_r, ack_nxt, ackph_r, ackph_nxt, rw_r, rw_nxt, hi_r, hi_nxt;
    logic        oe_r, oe_nxt, addr_hit;

    assign rx_byte  = {shreg_r[6:0], sda_s};
    assign tx_byte  = hi_r ? txw_r[15:8] : txw_r[7:0];
    assign addr_hit = rx_byte[7:1] == DEV_ADDR;
    // two bytes form one word, high byte first
    assign wr_data  = {wbuf_r, rx_byte};

    always_comb
    begin
        state_nxt = state_r;
        kind_nxt  = kind_r;
        cnt_nxt   = cnt_r;
        shreg_nxt = shreg_r;
        ptr_nxt   = ptr_r;
        wbuf_nxt  = wbuf_r;
        txw_nxt   = txw_r;
        ack_nxt   = ack_r;
        ackph_nxt = ackph_r;
        rw_nxt    = rw_r;
        hi_nxt    = hi_r;
        oe_nxt    = oe_r;
        wr_stb    = 1'b0;
        rd_stb    = 1'b0;
        if (bus_stop)
        begin
            state_nxt = monitor_pkg::BUS_IDLE;
            oe_nxt    = 1'b0;
        end
        else if (bus_start)
        begin
            state_nxt = monitor_pkg::BUS_RX;
            kind_nxt  = monitor_pkg::RX_ADDR;
            cnt_nxt   = 3'h0;
            oe_nxt    = 1'b0;
        end
        else
        begin
            case (state_r)
                monitor_pkg::BUS_RX:
                    if (scl_rise)
                    begin
                        shreg_nxt = rx_byte;
                        cnt_nxt   = cnt_r + 3'h1;
                        if (cnt_r == `BIT_LAST)
                        begin
                            state_nxt = monitor_pkg::BUS_ACK;
                            ackph_nxt = 1'b0;
                            ack_nxt   = 1'b1;
                            case (kind_r)
                                monitor_pkg::RX_ADDR:
                                begin
                                    ack_nxt = addr_hit;
                                    rw_nxt  = rx_byte[0];
                                    if (addr_hit && rx_byte[0])
                                    begin
                                        txw_nxt = read_word(ptr_r, cfg_r, status_r, mask_r,
                                                            shunt_r);
                                        hi_nxt  = 1'b1;
                                        rd_stb  = ptr_r == `PTR_STATUS;
                                    end
                                end
                                monitor_pkg::RX_PTR:
                                begin
                                    ptr_nxt = rx_byte;
                                    hi_nxt  = 1'b1;
                                end
                                default:
                                begin
                                    if (hi_r)
                                        wbuf_nxt = rx_byte;
                                    else
                                        wr_stb = 1'b1;
                                    hi_nxt = !hi_r;
                                end
                            endcase
                        end
                    end
                monitor_pkg::BUS_ACK:
                    if (scl_fall)
                    begin
                        if (!ackph_r)
                        begin
                            oe_nxt    = ack_r;
                            ackph_nxt = 1'b1;
                        end
                        else
                        begin
                            cnt_nxt = 3'h0;
                            if (!ack_r)
                            begin
                                state_nxt = monitor_pkg::BUS_IDLE;
                                oe_nxt    = 1'b0;
                            end
                            else if (kind_r == monitor_pkg::RX_ADDR && rw_r)
                            begin
                                state_nxt = monitor_pkg::BUS_TX;
                                oe_nxt    = !txw_r[15];
                            end
                            else
                            begin
                                state_nxt = monitor_pkg::BUS_RX;
                                oe_nxt    = 1'b0;
                                kind_nxt  = (kind_r == monitor_pkg::RX_ADDR)
                                            ? monitor_pkg::RX_PTR : monitor_pkg::RX_DATA;
                            end
                        end
                    end
                monitor_pkg::BUS_TX:
                    if (scl_rise)
                    begin
                        cnt_nxt = cnt_r + 3'h1;
                        if (cnt_r == `BIT_LAST)
                            state_nxt = monitor_pkg::BUS_TXACK;
                    end
                    else if (scl_fall)
                        oe_nxt = !tx_byte[~cnt_r];
                monitor_pkg::BUS_TXACK:
                    if (scl_fall)
                        oe_nxt = 1'b0;
                    else if (scl_rise)
                    begin
                        if (sda_s)
                            state_nxt = monitor_pkg::BUS_IDLE;
                        else
                        begin
                            state_nxt = monitor_pkg::BUS_TX;
                            hi_nxt    = !hi_r;
                            // a repeated word re-samples, so a held status read clears again
                            if (!hi_r)
                            begin
                                txw_nxt = read_word(ptr_r, cfg_r, status_r, mask_r, shunt_r);
                                rd_stb  = ptr_r == `PTR_STATUS;
                            end
                        end
                    end
                default:
                    state_nxt = monitor_pkg::BUS_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (srst)
        begin
            state_r <= monitor_pkg::BUS_IDLE;
            kind_r  <= monitor_pkg::RX_ADDR;
            cnt_r   <= 3'h0;
            shreg_r <= 8'h00;
            ptr_r   <= 8'h00;
            wbuf_r  <= 8'h00;
            txw_r   <= `ZERO_WORD;
            ack_r   <= 1'b0;
            ackph_r <= 1'b0;
            rw_r    <= 1'b0;
            hi_r    <= 1'b1;
            oe_r    <= 1'b0;
            sda_o   <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            kind_r  <= kind_nxt;
            cnt_r   <= cnt_nxt;
            shreg_r <= shreg_nxt;
            ptr_r   <= ptr_nxt;
            wbuf_r  <= wbuf_nxt;
            txw_r   <= txw_nxt;
            ack_r   <= ack_nxt;
            ackph_r <= ackph_nxt;
            rw_r    <= rw_nxt;
            hi_r    <= hi_nxt;
            oe_r    <= oe_nxt;
            sda_o   <= 1'b0;
        end
    end
    assign sda_oe_o = oe_r;

    // ---------------- assertions ----------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst);

    AST_CONV_READY_FLAG_SET: assert property (cnv_evt |=> status_r[`ST_CONV_READY_FLAG])
        else $error("conversion-ready did not set after conversion");
    AST_CFG_KEEP: assert property (cfg_wr && !cnv_evt && !rd_stb && !conv_edge
        && wr_data[`CFG_MODE_HI:0] == `MODE_POWER_DOWN
        |=> status_r[`ST_CONV_READY_FLAG] == $past(status_r[`ST_CONV_READY_FLAG]))
        else $error("power-down config write disturbed conversion-ready");
    AST_CONV_READY_FLAG_RDCLR: assert property (rd_stb && !cnv_evt |=> !status_r[`ST_CONV_READY_FLAG])
        else $error("status read left conversion-ready set");
    AST_ALERT_HOLD: assert property (status_r[`ST_ALERT] && !rd_stb
        && mask_r[`MSK_ALERT_EN] |=> status_r[`ST_ALERT])
        else $error("alert flag dropped without read or disable");
    AST_ALERT_OFF: assert property (!mask_r[`MSK_ALERT_EN]
        |=> !status_r[`ST_ALERT] ##1 pins_o.alert_n)
        else $error("alert active while function disabled");
    AST_ALERT_SET: assert property (mask_r[`MSK_ALERT_EN]
        && |(status_r[`ST_TOP:`ST_CONV_READY_FLAG] & mask_r[`ST_TOP:`ST_CONV_READY_FLAG])
        |=> status_r[`ST_ALERT] ##1 !pins_o.alert_n)
        else $error("unmasked flag did not raise alert");
    AST_MASK_BLOCK: assert property (!status_r[`ST_ALERT]
        && !(|(status_r[`ST_TOP:`ST_CONV_READY_FLAG] & mask_r[`ST_TOP:`ST_CONV_READY_FLAG]))
        |=> !status_r[`ST_ALERT])
        else $error("masked flags raised alert");
    AST_OVF_SET: assert property (ovf_evt && !rd_stb ##1 !rd_stb
        |-> status_r[`ST_OVF] && $stable(pins_o.critical_pos_flag))
        else $error("overflow flag missing or touched a pin");
    AST_CRITICAL_POS_FLAG_PIN: assert property (!mask_r[`MSK_CRITICAL_POS_FLAG_EN] |=> !pins_o.critical_pos_flag)
        else $error("critical pin active while disabled");
    AST_LIMIT_PIN: assert property (!mask_r[`MSK_LIMIT_EN] |=> !pins_o.limit)
        else $error("over-limit pin active while disabled");
    AST_WARN_PIN: assert property (!mask_r[`MSK_WARN_EN] |=> !pins_o.warn)
        else $error("warning pin active while disabled");
    AST_REARM: assert property (rd_stb && critical_pos_flag_pos_s |=> status_r[`ST_CRITICAL_POS_FLAG_POS])
        else $error("violated limit not set again after read");
    AST_FS40: assert property (cnv_evt && cfg_r[`CFG_GAIN_HI:`CFG_GAIN_LO] == 2'h0
        && $signed(cdata_r) > $signed(`SHUNT_FS_BASE) |=> shunt_r == 16'h0FA0)
        else $error("40 mV range positive clamp wrong");

    COV_STATUS_READ: cover property (rd_stb ##1 status_r[`ST_CRITICAL_POS_FLAG_POS]);
    COV_CONV_DONE:   cover property (cnv_evt ##1 status_r[`ST_CONV_READY_FLAG]);
    COV_ALERT:       cover property (status_r[`ST_ALERT] ##1 !pins_o.alert_n);
    COV_WRITE:       cover property (msk_wr);
endmodule

//--- core/monitor_consts.svh
// offsets, bit positions, reset values and limits of the alert and shunt block
`ifndef MONITOR_CONSTS_SVH
`define MONITOR_CONSTS_SVH
`define PTR_CONFIG      8'h00
`define PTR_STATUS      8'h01
`define PTR_MASK        8'h02
`define PTR_SHUNT       8'h03
`define CONFIG_RST_VAL  16'h399F
`define ZERO_WORD       16'h0000
`define MASK_WR_BITS    16'hFFEF
`define STATUS_USED     16'hFFF8
`define CFG_SOFT_RST    15
`define CFG_GAIN_HI     12
`define CFG_GAIN_LO     11
`define CFG_MODE_HI     2
`define MODE_POWER_DOWN 3'h0
`define MODE_ADC_OFF    3'h4
`define ST_TOP          15
`define ST_LIMIT_LO     8
`define ST_CRITICAL_POS_FLAG_POS     7
`define ST_CRITICAL_POS_FLAG_NEG     6
`define ST_CONV_READY_FLAG         5
`define ST_ALERT        4
`define ST_OVF          3
`define MSK_ALERT_EN    3
`define MSK_CRITICAL_POS_FLAG_EN     2
`define MSK_LIMIT_EN    1
`define MSK_WARN_EN     0
`define LIM_LIMIT_HI    2
`define LIM_WARN_LO     3
`define LIM_WARN_HI     7
`define SHUNT_FS_BASE   16'h0FA0
`define BIT_LAST        3'h7
`define I2C_ADDR_DFLT   7'h40
`define SYNC_IDLE       7'h60
`endif

//--- core/monitor_pkg.sv
// types shared by the alert and shunt block
package monitor_pkg;
    typedef enum logic [2:0] {BUS_IDLE, BUS_RX, BUS_ACK, BUS_TX, BUS_TXACK} bus_state_t;
    typedef enum logic [1:0] {RX_ADDR, RX_PTR, RX_DATA} rx_kind_t;
    typedef struct packed {
        logic        done;
        logic        ovf;
        logic        critical_pos_flag_pos;
        logic        critical_pos_flag_neg;
        logic [15:0] shunt;
    } conv_in_t;
    typedef struct packed {
        logic critical_pos_flag;
        logic limit;
        logic warn;
        logic alert_n;
    } pins_t;
endpackage

//--- dv/i2c_host_model.sv
// two-wire host model: drives scl, pulls sda low, reads and writes 16-bit registers
`timescale 1ns/1ps
`include "monitor_consts.svh"
module i2c_host_model #(
    parameter logic [6:0] ADDR = `I2C_ADDR_DFLT
) (
    input  wire logic mclk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    initial
    begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    // data moves mid-low only, so a data bit never looks like a start or stop
    task automatic bit_io(input logic b, output logic r);
        scl_o = 1'b0;
        tick(2);
        sda_low_o = ~b;
        tick(3);
        scl_o = 1'b1;
        tick(4);
        r = sda_i;
    endtask
    // start or repeated start when stp is 0, stop when 1
    task automatic cond(input logic stp);
        logic r;
        bit_io(~stp, r);
        sda_low_o = ~stp;
        tick(4);
    endtask
    task automatic byte_io(input logic [7:0] tx, input logic ack, output logic [7:0] rx);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(tx[i], r);
            rx[i] = r;
        end
        bit_io(ack, r);
    endtask
    task automatic reg_wr(input logic [7:0] p, input logic [15:0] d);
        logic [7:0] x;
        cond(1'b0);
        byte_io({ADDR, 1'b0}, 1'b1, x);
        byte_io(p, 1'b1, x);
        byte_io(d[15:8], 1'b1, x);
        byte_io(d[7:0], 1'b1, x);
        cond(1'b1);
    endtask
    task automatic reg_rd(input logic [7:0] p, output logic [15:0] d);
        logic [7:0] x;
        cond(1'b0);
        byte_io({ADDR, 1'b0}, 1'b1, x);
        byte_io(p, 1'b1, x);
        cond(1'b0);
        byte_io({ADDR, 1'b1}, 1'b1, x);
        byte_io(8'hFF, 1'b0, d[15:8]);
        byte_io(8'hFF, 1'b1, d[7:0]);
        cond(1'b1);
    endtask
endmodule

//--- dv/tb_alert_status_shunt.sv
// self-checking bench for the alert, status and shunt format block
`timescale 1ns/1ps
`include "monitor_consts.svh"
module tb_alert_status_shunt;
    logic                  mclk_i = 1'b0;
    logic                  rst_n_i = 1'b0;
    logic                  conv_clk_i = 1'b0;
    monitor_pkg::conv_in_t cin = '0;
    logic [7:0]            lim = 8'h00;
    logic                  cvt = 1'b0;
    logic                  sda_oe;
    logic                  scl;
    logic                  host_low;
    wire logic             sda = ~(host_low | sda_oe);
    monitor_pkg::pins_t    pins;
    logic [15:0]           rd;
    logic                  sda_val;
    int                    n_mismatch = 0;
    int                    checked = 0;
    int                    cyc = 0;
    // gain, raw code, expected register
    logic [33:0] fmt [9] = '{{2'd3, 16'h7D02, 16'h7D00}, {2'd3, 16'h82FE, 16'h8300},
        {2'd2, 16'h7D02, 16'h3E80}, {2'd2, 16'h82FE, 16'hC180}, {2'd1, 16'h7D02, 16'h1F40},
        {2'd1, 16'h82FE, 16'hE0C0}, {2'd0, 16'h7D02, 16'h0FA0}, {2'd0, 16'h82FE, 16'hF060},
        {2'd0, 16'h0F9F, 16'h0F9F}};
    // done, ovf, clearing action, expected status
    logic [19:0] ev [5] = '{20'h80020, 20'h90000, 20'hA0000, 20'hB0020, 20'h40008};
    always #12.5 mclk_i = ~mclk_i;
    initial
    begin
        #7;
        forever #80 conv_clk_i = ~conv_clk_i;
    end
    i2c_host_model u_host (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));
    alert_status_shunt u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .conv_clk_i(conv_clk_i),
        .conv_i(cin), .limit_flags_i(lim), .convert_i(cvt), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_val), .sda_oe_o(sda_oe), .pins_o(pins));
    task automatic print_verdict;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    task automatic pulse(input logic d, input logic o, input logic [15:0] s);
        @(negedge conv_clk_i);
        cin.done = d;
        cin.ovf = o;
        cin.shunt = s;
        @(negedge conv_clk_i);
        cin.done = 1'b0;
        cin.ovf = 1'b0;
        wt(12);
    endtask
    task automatic critical_pos_flag(input logic [1:0] c);
        @(negedge conv_clk_i);
        cin.critical_pos_flag_pos = c[1];
        cin.critical_pos_flag_neg = c[0];
        wt(12);
    endtask
    task automatic rdchk(input logic [7:0] p, input logic [15:0] e);
        u_host.reg_rd(p, rd);
        chk(rd, e);
    endtask
    task automatic mask(input logic [15:0] m);
        u_host.reg_wr(`PTR_MASK, m);
    endtask
    always @(posedge mclk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            n_mismatch++;
            print_verdict;
        end
    end
    initial
    begin
        // reset held long enough for the conversion domain to see three edges
        wt(20);
        rst_n_i = 1'b1;
        wt(4);
        foreach (fmt[i])
        begin
            u_host.reg_wr(`PTR_CONFIG, (`CONFIG_RST_VAL & 16'hE7FF) | {3'h0, fmt[i][33:32], 11'h000});
            pulse(1'b1, 1'b0, fmt[i][31:16]);
            rdchk(`PTR_SHUNT, fmt[i][15:0]);
        end
        $display("shunt format test done");
        mask(16'h0007);
        foreach (ev[i])
        begin
            pulse(ev[i][19], ev[i][18], 16'h0000);
            case (ev[i][17:16])
                2'h1:
                begin
                    cvt = 1'b1;
                    wt(4);
                    cvt = 1'b0;
                    wt(4);
                end
                2'h2: u_host.reg_wr(`PTR_CONFIG, `CONFIG_RST_VAL);
                2'h3: u_host.reg_wr(`PTR_CONFIG, 16'h3998);
                default: ;
            endcase
            rdchk(`PTR_STATUS, ev[i][15:0]);
        end
        chk({12'h000, pins}, 16'h0001);
        $display("conversion ready test done");
        u_host.reg_wr(`PTR_CONFIG, `CONFIG_RST_VAL);
        lim = 8'h81;
        critical_pos_flag(2'b11);
        chk({12'h000, pins}, 16'h000F);
        mask(16'h0000);
        chk({12'h000, pins}, 16'h0001);
        u_host.reg_rd(`PTR_STATUS, rd);
        rdchk(`PTR_STATUS, 16'h81C0);
        $display("limit pin test done");
        lim = 8'h80;
        critical_pos_flag(2'b00);
        u_host.reg_rd(`PTR_STATUS, rd);
        mask(16'h0008);
        chk({12'h000, pins}, 16'h0001);
        mask(16'h8008);
        chk({12'h000, pins}, 16'h0000);
        rdchk(`PTR_STATUS, 16'h8010);
        mask(16'h8000);
        chk({12'h000, pins}, 16'h0001);
        rdchk(`PTR_STATUS, 16'h8000);
        pulse(1'b1, 1'b0, 16'h0000);
        u_host.reg_wr(`PTR_CONFIG, 16'h399C);
        rdchk(`PTR_STATUS, 16'h8020);
        // soft reset drops the bus mid-acknowledge; the host ignores the missing ack
        u_host.reg_wr(`PTR_CONFIG, 16'h8000);
        rdchk(`PTR_MASK, 16'h0000);
        rdchk(`PTR_CONFIG, `CONFIG_RST_VAL);
        rdchk(8'h07, 16'h0000);
        $display("alert test done");
        rst_n_i = 1'b0;
        wt(20);
        rst_n_i = 1'b1;
        wt(4);
        chk({12'h000, pins}, 16'h0001);
        chk({15'h0000, sda_val}, 16'h0000);
        rdchk(`PTR_MASK, 16'h0000);
        rdchk(`PTR_SHUNT, 16'h0000);
        pulse(1'b1, 1'b0, 16'h82FE);
        rdchk(`PTR_SHUNT, 16'h8300);
        $display("reset test done");
        print_verdict;
    end
endmodule
